// ===== logic/cam_io_pkg.sv
/*
 * shared constants and carrier types for the camera i/o line block.
 * assumes a single 20 mhz system clock and no register bus.
 */
package cam_io_pkg;

    localparam int unsigned NUM_LINES        = 7;
    localparam int unsigned NUM_OUT          = 6;
    localparam int unsigned CLK_HZ           = 20_000_000;
    localparam int unsigned US_PER_S         = 1_000_000;
    localparam int unsigned TICK_CYCLES      = CLK_HZ / US_PER_S;
    localparam int unsigned TICK_W           = 5;
    localparam int unsigned FILT_TIME_MAX_US = 1_000_000;
    localparam int unsigned FILT_W           = 20;
    localparam logic [FILT_W-1:0] FILT_TIME_RST = 20'h00000;
    localparam int unsigned IN_LINE_IDX      = 0;

    typedef enum logic [2:0] {
        SRC_OFF,
        SRC_FRAME,
        SRC_ROW,
        SRC_EXPO,
        SRC_SOFT,
        SRC_TIMER,
        SRC_COUNTER
    } out_src_t;

    typedef enum logic {
        DIR_INPUT,
        DIR_OUTPUT
    } line_dir_t;

    // per-output configuration
    typedef struct packed {
        out_src_t output_source_select;
        logic     output_polarity_invert;
    } out_cfg_t;

    // live sources from the sensor timing and generator blocks
    typedef struct packed {
        logic frame_readout_pulse;
        logic row_period_pulse;
        logic exposure_window;
        logic timer_pulse_source;
        logic counter_pulse_source;
    } src_bus_t;

endpackage

// ===== logic/glitch_filter.sv
/*
 * glitch filter for one input line: synchroniser, microsecond tick
 * and a stability counter. assumes time_us stays below the maximum.
 */
`timescale 1ns/1ps
module glitch_filter
    import cam_io_pkg::*;
#(
    parameter int unsigned TW = FILT_W
) (
    // clock and reset
    input  wire logic          clk_sys,
    input  wire logic          nrst,
    // raw pin and setting
    input  wire logic          pin_in,
    input  wire logic [TW-1:0] time_us,
    // filtered level
    output logic               level_out
);
    import cam_io_pkg::*;

    typedef struct packed {
        logic              sync1;
        logic              sync2;
        logic [TICK_W-1:0] tick_cnt;
        logic [TW-1:0]     us_cnt;
        logic              level;
    } filt_st_t;

    filt_st_t st_q;
    filt_st_t st_d;
    logic     tick;

    assign tick = (st_q.tick_cnt == TICK_W'(TICK_CYCLES - 1));

    always_comb begin
        st_d       = st_q;
        st_d.sync1 = pin_in;
        st_d.sync2 = st_q.sync1;
        // tick phase restarts while the pin agrees, so a change is always
        // timed in whole microseconds and never accepted a fraction early
        if (tick || st_q.sync2 == st_q.level) begin
            st_d.tick_cnt = '0;
        end else begin
            st_d.tick_cnt = st_q.tick_cnt + 1'b1;
        end
        if (st_q.sync2 == st_q.level) begin
            // any bounce back restarts the wait
            st_d.us_cnt = '0;
        end else if (st_q.us_cnt >= time_us) begin
            // accepted after the full filter time, zero passes through
            st_d.level  = st_q.sync2;
            st_d.us_cnt = '0;
        end else if (tick) begin
            st_d.us_cnt = st_q.us_cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign level_out = st_q.level;

    AST_LEVEL_NEEDS_STABLE: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        $changed(st_q.level) |-> $past(st_q.sync2) == st_q.level)
        else $error("filtered level changed without raw agreement");

    AST_ZERO_TIME_FAST: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (time_us == '0 && st_q.sync2 != st_q.level) |=> st_q.level ==
            $past(st_q.sync2))
        else $error("zero filter time did not pass change in one cycle");

endmodule

// ===== logic/camera_io_line_control.sv
/*
 * camera digital i/o lines: one filtered input, six output lines with
 * source select and polarity. assumes sources are on clk_sys already.
 */
`timescale 1ns/1ps
module camera_io_line_control
    import cam_io_pkg::*;
(
    // clock and reset
    input  wire logic                    clk_sys,
    input  wire logic                    nrst,
    // connector input
    input  wire logic                    first_input_pin,
    // configuration
    input  wire logic [FILT_W-1:0]       glitch_filter_time,
    input  wire cam_io_pkg::out_cfg_t    out_cfg [NUM_OUT],
    input  wire logic                    software_level_value,
    input  wire logic [2:0]              line_index_select,
    // internal sources
    input  wire cam_io_pkg::src_bus_t    src,
    // outputs
    output logic                         filtered_input,
    output logic [NUM_OUT-1:0]           line_out,
    output cam_io_pkg::line_dir_t        line_direction
);
    import cam_io_pkg::*;

    // checking aid only: how long the synchronised pin has disagreed with
    // the filtered level; wide enough for the longest filter time
    localparam int unsigned RUN_W = 25;

    typedef struct packed {
        logic [NUM_OUT-1:0] out;
        logic [FILT_W-1:0]  ftime;
        line_dir_t          dir;
        logic               chk_s1;
        logic               chk_s2;
        logic [RUN_W-1:0]   run;
        logic [RUN_W-1:0]   run_cfg;
    } top_st_t;

    top_st_t           st_q;
    top_st_t           st_d;
    logic [NUM_OUT-1:0] sel_val;
    logic               filt_level;

    glitch_filter #(
        .TW        (FILT_W)
    ) u_filter (
        .clk_sys   (clk_sys),
        .nrst      (nrst),
        .pin_in    (first_input_pin),
        .time_us   (st_q.ftime),
        .level_out (filt_level)
    );

    always_comb begin
        for (int i = 0; i < NUM_OUT; i++) begin
            case (out_cfg[i].output_source_select)
                SRC_OFF:     sel_val[i] = 1'b0;
                SRC_FRAME:   sel_val[i] = src.frame_readout_pulse;
                SRC_ROW:     sel_val[i] = src.row_period_pulse;
                SRC_EXPO:    sel_val[i] = src.exposure_window;
                SRC_SOFT:    sel_val[i] = software_level_value;
                SRC_TIMER:   sel_val[i] = src.timer_pulse_source;
                SRC_COUNTER: sel_val[i] = src.counter_pulse_source;
                default:     sel_val[i] = 1'b0;
            endcase
        end
    end

    always_comb begin
        st_d = st_q;
        // registered so a select change cannot make a combinational spike
        st_d.out = sel_val;
        for (int i = 0; i < NUM_OUT; i++) begin
            if (out_cfg[i].output_polarity_invert) begin
                st_d.out[i] = ~sel_val[i];
            end
        end
        // out-of-range settings are clamped to the maximum
        if (glitch_filter_time > FILT_W'(FILT_TIME_MAX_US)) begin
            st_d.ftime = FILT_W'(FILT_TIME_MAX_US);
        end else begin
            st_d.ftime = glitch_filter_time;
        end
        st_d.dir = (line_index_select == 3'(IN_LINE_IDX)) ?
                   DIR_INPUT : DIR_OUTPUT;
        // own copy of the pin synchroniser, so the checks below see the
        // pin with the same two-cycle delay as the filter does
        st_d.chk_s1 = first_input_pin;
        st_d.chk_s2 = st_q.chk_s1;
        if (st_q.chk_s2 == filt_level) begin
            st_d.run = '0;
        end else if (st_q.run != '1) begin
            st_d.run = st_q.run + 1'b1;
        end
        // a new filter time restarts this count, since the filter then
        // measures against the new limit
        if (st_q.chk_s2 == filt_level || st_d.ftime != st_q.ftime) begin
            st_d.run_cfg = '0;
        end else if (st_q.run_cfg != '1) begin
            st_d.run_cfg = st_q.run_cfg + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_q.out   <= '0;
            st_q.ftime <= FILT_TIME_RST;
            st_q.dir   <= DIR_INPUT;
            st_q.chk_s1  <= 1'b0;
            st_q.chk_s2  <= 1'b0;
            st_q.run     <= '0;
            st_q.run_cfg <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign line_out       = st_q.out;
    assign filtered_input = filt_level;
    assign line_direction = st_q.dir;

    AST_SRC_FOLLOWS: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        ($changed(out_cfg[0]) &&
         out_cfg[0].output_source_select == SRC_FRAME &&
         !out_cfg[0].output_polarity_invert) |=>
        line_out[0] == $past(src.frame_readout_pulse))
        else $error("new source selection not applied next cycle");

    AST_OFF_QUIET: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (out_cfg[0].output_source_select == SRC_OFF &&
         !out_cfg[0].output_polarity_invert) |=> line_out[0] == 1'b0)
        else $error("line with source off shows activity");

    AST_INVERT: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (out_cfg[1].output_polarity_invert &&
         out_cfg[1].output_source_select == SRC_SOFT) |=>
        line_out[1] == !$past(software_level_value))
        else $error("inverted soft level wrong");

    AST_SOFT: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (!out_cfg[2].output_polarity_invert &&
         out_cfg[2].output_source_select == SRC_SOFT) |=>
        line_out[2] == $past(software_level_value))
        else $error("soft level not driven");

    AST_EXPO: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (!out_cfg[3].output_polarity_invert &&
         out_cfg[3].output_source_select == SRC_EXPO) |=>
        line_out[3] == $past(src.exposure_window))
        else $error("exposure window not forwarded");

    AST_TIMER: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (!out_cfg[4].output_polarity_invert &&
         out_cfg[4].output_source_select == SRC_TIMER) |=>
        line_out[4] == $past(src.timer_pulse_source))
        else $error("timer pulse not forwarded");

    AST_COUNTER: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (!out_cfg[5].output_polarity_invert &&
         out_cfg[5].output_source_select == SRC_COUNTER) |=>
        line_out[5] == $past(src.counter_pulse_source))
        else $error("counter pulse not forwarded");

    AST_DIR: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (line_index_select == 3'h0) |=> line_direction == DIR_INPUT)
        else $error("line zero not reported as input");

    AST_FTIME_MAX: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        st_q.ftime <= FILT_W'(FILT_TIME_MAX_US))
        else $error("filter time beyond maximum");

    AST_FTIME_CLAMP: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (glitch_filter_time > FILT_W'(FILT_TIME_MAX_US)) |=>
        st_q.ftime == FILT_W'(FILT_TIME_MAX_US))
        else $error("oversized filter time not clamped");

    AST_DIR_OUT: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (line_index_select != 3'h0) |=> line_direction == DIR_OUTPUT)
        else $error("output line not reported as output");

    // the filtered level may only move once the pin has disagreed with it
    // for the whole filter time, and must move at most one cycle after
    sequence s_level_moved;
        $changed(filtered_input);
    endsequence

    sequence s_waited_full;
        $past(st_q.run) >= TICK_CYCLES * $past(st_q.ftime);
    endsequence

    AST_FILT_MIN_WAIT: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        s_level_moved |-> s_waited_full)
        else $error("filtered level moved before the filter time");

    AST_FILT_MAX_WAIT: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        st_q.run_cfg <= TICK_CYCLES * st_q.ftime + 1)
        else $error("filtered level late after a steady change");

    AST_FILT_SETTLE: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (st_q.chk_s2 == filtered_input) |=> $stable(filtered_input))
        else $error("filtered level moved while the pin agreed");

    // exposure edges reach the line one cycle later, rise and fall alike, so a flash
    // fires one clk_sys cycle after the exposure start through the output register
    AST_EXPO_RISE: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (out_cfg[3].output_source_select == SRC_EXPO &&
         !out_cfg[3].output_polarity_invert && $stable(out_cfg[3]) &&
         $rose(src.exposure_window)) |=> $rose(line_out[3]))
        else $error("exposure start not seen on its line");

    AST_EXPO_FALL: assert property (
        @(posedge clk_sys) disable iff (!nrst)
        (out_cfg[3].output_source_select == SRC_EXPO &&
         !out_cfg[3].output_polarity_invert && $stable(out_cfg[3]) &&
         $fell(src.exposure_window) && $past(nrst)) |=> $fell(line_out[3]))
        else $error("exposure end not seen on its line");

    // every output line, both polarities; inversion is an exclusive-or
    // on the chosen source, so one property per source covers both
    for (genvar g = 0; g < NUM_OUT; g++) begin : g_line_chk
        AST_LINE_OFF: assert property (
            @(posedge clk_sys) disable iff (!nrst)
            (out_cfg[g].output_source_select == SRC_OFF) |=>
            line_out[g] == $past(out_cfg[g].output_polarity_invert))
            else $error("line with source off not at its idle level");

        AST_LINE_FRAME: assert property (
            @(posedge clk_sys) disable iff (!nrst)
            (out_cfg[g].output_source_select == SRC_FRAME) |=>
            line_out[g] == ($past(src.frame_readout_pulse) ^
                            $past(out_cfg[g].output_polarity_invert)))
            else $error("frame readout pulse not on its line");

        AST_LINE_ROW: assert property (
            @(posedge clk_sys) disable iff (!nrst)
            (out_cfg[g].output_source_select == SRC_ROW) |=>
            line_out[g] == ($past(src.row_period_pulse) ^
                            $past(out_cfg[g].output_polarity_invert)))
            else $error("row period pulse not on its line");

        AST_LINE_EXPO: assert property (
            @(posedge clk_sys) disable iff (!nrst)
            (out_cfg[g].output_source_select == SRC_EXPO) |=>
            line_out[g] == ($past(src.exposure_window) ^
                            $past(out_cfg[g].output_polarity_invert)))
            else $error("exposure window not on its line");

        AST_LINE_SOFT: assert property (
            @(posedge clk_sys) disable iff (!nrst)
            (out_cfg[g].output_source_select == SRC_SOFT) |=>
            line_out[g] == ($past(software_level_value) ^
                            $past(out_cfg[g].output_polarity_invert)))
            else $error("software level not on its line");

        AST_LINE_TIMER: assert property (
            @(posedge clk_sys) disable iff (!nrst)
            (out_cfg[g].output_source_select == SRC_TIMER) |=>
            line_out[g] == ($past(src.timer_pulse_source) ^
                            $past(out_cfg[g].output_polarity_invert)))
            else $error("timer pulse not on its line");

        AST_LINE_COUNTER: assert property (
            @(posedge clk_sys) disable iff (!nrst)
            (out_cfg[g].output_source_select == SRC_COUNTER) |=>
            line_out[g] == ($past(src.counter_pulse_source) ^
                            $past(out_cfg[g].output_polarity_invert)))
            else $error("counter pulse not on its line");
    end

endmodule

// ===== tb/trigger_source.sv
/*
 * external trigger source model: drives the camera input pin with
 * pulses of a chosen length. assumes clk_sys comes from the bench.
 */
`timescale 1ns/1ps
module trigger_source (
    // clock
    input  wire logic        clk_sys,
    // pulse request
    input  wire logic        go,
    input  wire logic [15:0] width,
    // connector pin
    output logic             pin
);
    int unsigned left_q = 0;
    // pin idles low between pulses, as the pull-down on the input holds it
    initial pin = 1'b0;
    always @(posedge clk_sys) begin
        if (go) begin
            left_q = width;
        end
        pin <= (left_q != 0);
        if (left_q != 0) begin
            left_q = left_q - 1;
        end
    end
endmodule

// ===== tb/testbench.sv
/*
 * self-checking bench for the camera i/o line block.
 * assumes the trigger source model drives the input pin.
 */
`timescale 1ns/1ps
module testbench;
    import cam_io_pkg::*;
    typedef struct packed {
        out_src_t s;
        logic     inv;
        src_bus_t b;
        logic     sw;
        logic     e;
    } row_t;
    logic               clk_sys;
    logic               nrst;
    logic               go;
    logic               sw;
    logic [15:0]        width;
    logic [FILT_W-1:0]  ftime;
    out_cfg_t           cfg [NUM_OUT];
    logic [2:0]         idx;
    src_bus_t           src;
    logic               pin;
    logic               filt;
    logic [NUM_OUT-1:0] lout;
    line_dir_t          dir;
    int                 err_count = 0;
    int                 n_checks = 0;
    int                 n;
    // source bus order: frame, row, exposure, timer, counter
    row_t rows [16] = '{
        '{SRC_OFF, 1'b0, 5'h1f, 1'b1, 1'b0},
        '{SRC_OFF, 1'b1, 5'h1f, 1'b1, 1'b1},
        '{SRC_FRAME, 1'b0, 5'h10, 1'b0, 1'b1},
        '{SRC_FRAME, 1'b1, 5'h0f, 1'b1, 1'b1},
        '{SRC_ROW, 1'b0, 5'h08, 1'b0, 1'b1},
        '{SRC_ROW, 1'b1, 5'h08, 1'b0, 1'b0},
        '{SRC_EXPO, 1'b0, 5'h1b, 1'b1, 1'b0},
        '{SRC_EXPO, 1'b0, 5'h04, 1'b0, 1'b1},
        '{SRC_EXPO, 1'b0, 5'h1b, 1'b1, 1'b0},
        '{SRC_EXPO, 1'b1, 5'h04, 1'b0, 1'b0},
        '{SRC_SOFT, 1'b0, 5'h00, 1'b1, 1'b1},
        '{SRC_SOFT, 1'b1, 5'h1f, 1'b0, 1'b1},
        '{SRC_TIMER, 1'b0, 5'h02, 1'b0, 1'b1},
        '{SRC_TIMER, 1'b1, 5'h1d, 1'b1, 1'b1},
        '{SRC_COUNTER, 1'b0, 5'h01, 1'b0, 1'b1},
        '{SRC_COUNTER, 1'b1, 5'h01, 1'b0, 1'b0}};

    trigger_source trigger_source_inst (.clk_sys(clk_sys), .go(go),
        .width(width), .pin(pin));
    camera_io_line_control camera_io_line_control_inst (
        .clk_sys(clk_sys), .nrst(nrst), .first_input_pin(pin),
        .glitch_filter_time(ftime), .out_cfg(cfg),
        .software_level_value(sw), .line_index_select(idx), .src(src),
        .filtered_input(filt), .line_out(lout), .line_direction(dir));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // inputs always move 1 ns after the edge so sampling never races
    task automatic step(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_rng(input int got, input int lo, input int hi);
        chk(32'(got >= lo && got <= hi), 32'h1);
    endtask
    task automatic set_all(input out_src_t s, input logic inv);
        for (int i = 0; i < NUM_OUT; i++) begin
            cfg[i] = '{s, inv};
        end
    endtask
    task automatic wait_filt(input logic v, input int lim);
        n = 0;
        while (filt !== v && n < lim) begin
            step(1);
            n++;
        end
    endtask
    task automatic pulse(input int w);
        width = 16'(w);
        go = 1'b1;
        step(1);
        go = 1'b0;
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        #1_000_000;
        err_count++;
        results();
    end

    initial begin
        nrst = 1'b0;
        go = 1'b0;
        sw = 1'b0;
        width = 16'h0000;
        ftime = 20'h00000;
        idx = 3'h0;
        src = '0;
        set_all(SRC_OFF, 1'b0);
        step(3);
        chk(lout, 32'h0);
        chk(dir, DIR_INPUT);
        nrst = 1'b1;
        step(1);
        foreach (rows[r]) begin
            set_all(rows[r].s, rows[r].inv);
            src = rows[r].b;
            sw = rows[r].sw;
            step(1);
            chk(lout, {6{rows[r].e}});
        end
        $display("test source table done");
        set_all(SRC_OFF, 1'b0);
        sw = 1'b1;
        for (int k = 0; k < NUM_OUT; k++) begin
            cfg[k] = '{SRC_SOFT, 1'b0};
            step(1);
            chk(lout, 32'h1 << k);
            cfg[k] = '{SRC_OFF, 1'b0};
        end
        for (int k = 0; k < NUM_LINES; k++) begin
            idx = 3'(k);
            step(1);
            chk(dir, (k == 0) ? DIR_INPUT : DIR_OUTPUT);
        end
        $display("test lines and direction done");
        // zero filter time still pays the synchroniser latency
        pulse(40);
        wait_filt(1'b1, 8);
        chk_rng(n, 2, 5);
        step(50);
        ftime = 20'h00002;
        step(5);
        pulse(30);
        wait_filt(1'b1, 80);
        chk(filt, 32'h0);
        step(20);
        pulse(100);
        wait_filt(1'b1, 80);
        chk_rng(n, 38, 63);
        wait_filt(1'b0, 200);
        chk(filt, 32'h0);
        $display("test glitch filter done");
        // oversized filter time is left to the design's own clamp check
        ftime = 20'hfffff;
        set_all(SRC_OFF, 1'b1);
        idx = 3'h3;
        step(2);
        chk(lout, 32'h3f);
        chk(dir, DIR_OUTPUT);
        ftime = 20'h00000;
        step(2);
        pulse(60);
        wait_filt(1'b1, 8);
        chk(filt, 32'h1);
        nrst = 1'b0;
        step(1);
        chk(lout, 32'h0);
        chk(dir, DIR_INPUT);
        chk(filt, 32'h0);
        nrst = 1'b1;
        step(1);
        chk(lout, 32'h3f);
        chk(filt, 32'h0);
        $display("test mid-run reset done");
        results();
    end
endmodule
